// ### axil_port.sv
// AXI4-Lite slave front end, one write and one read in flight
// assumes the register file answers reads combinationally in the same cycle
`default_nettype none
module axil_port
   import pinmux_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pinmux_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [pinmux_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pinmux_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [pinmux_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   reg_access_if.initiator regs
);
   logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] data_ff, nxt_data, rdata_ff, nxt_rdata;
   logic [3:0] strb_ff, nxt_strb;
   logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

   // address and data taken in either order, held until the write
   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign arready = !rvalid_ff;
   assign regs.wr_en = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign regs.wr_addr = addr_ff;
   assign regs.wr_data = data_ff;
   assign regs.wr_strb = strb_ff;
   assign regs.rd_en = arvalid && arready;
   assign regs.rd_addr = araddr;

   always_comb begin
      nxt_aw_hold = aw_hold_ff;
      nxt_w_hold = w_hold_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_strb = strb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (awvalid && awready) begin
         nxt_aw_hold = 1'b1;
         nxt_addr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_w_hold = 1'b1;
         nxt_data = wdata;
         nxt_strb = wstrb;
      end
      if (regs.wr_en) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = regs.wr_err ? RESP_DECERR : RESP_OKAY;
      end else if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (regs.rd_en) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = regs.rd_data;
         nxt_rresp = regs.rd_err ? RESP_DECERR : RESP_OKAY;
      end else if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         addr_ff <= '0;
         data_ff <= '0;
         strb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff <= nxt_w_hold;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         strb_ff <= nxt_strb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
endmodule : axil_port
`default_nettype wire

// ### input_sync.sv
// two flop synchroniser for asynchronous pin levels
// assumes levels only, no pulses shorter than two clocks
`default_nettype none
module input_sync #(
   parameter int WIDTH = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   // first stage feeds only the second
   always_comb begin
      nxt_meta = din;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign dout = sync_ff;
endmodule : input_sync
`default_nettype wire

// ### pin_partner.sv
// external circuitry on the five port c pins: pull-up plus optional driver
// assumes pin_oe_n low means the device drives the pin
`default_nettype none
module pin_partner (
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe_n,
   input wire logic [4:0] ext_val,
   input wire logic [4:0] ext_en,
   output logic [4:0] pin_in
);
   // device drive wins; a pin nobody drives floats up to the pull-up
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         pin_in[k] = !pin_oe_n[k] ? pin_out[k] : (ext_en[k] ? ext_val[k] : 1'b1);
      end
   end
endmodule : pin_partner
`default_nettype wire

// ### pinmux_pkg.sv
// constants for the port c pin function multiplexer and its register map
// assumes a single 10 MHz clock and an AXI4-Lite register bus with 32-bit data
//
// Summary of operation
// [RQ1] comparator output function with output direction drives combined comparator result on pin 4
// [RQ2] pwm b, c, d drive their pins over the latch when direction is output
// [RQ3] each pwm pin may float while a pwm shutdown event is active
// [RQ4] reference voltage output on pin 2 cuts its digital paths, direction ignored
// [RQ5] low voltage programming bit makes pin 3 programming entry only
// [RQ6] external interrupts 0 to 2 come from pins 0 to 2 when input
// [RQ7] pins 0 to 3, as inputs, route to converter channels 4 to 7
// [RQ8] pin 0 comparator non-inverting, pins 1 to 3 inverting, selection shared with converter
// [RQ9] reference output and programming entry override the direction bit
// [RQ10] pins 0 and 1 carry high and low reference inputs when analogue
// [RQ11] otherwise output direction drives latch; input direction reads pin into port value
`default_nettype none
package pinmux_pkg;
   localparam int PIN_COUNT = 5;
   localparam int ANA_COUNT = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INPUT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FUNCTION = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ANALOG = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h1C;
   localparam logic [4:0] RST_DIRECTION = 5'h1F;
   localparam logic [4:0] RST_LATCH = 5'h00;
   localparam logic [7:0] RST_FUNCTION = 8'h00;
   localparam logic [3:0] RST_ANALOG = 4'h0;
   localparam logic [0:0] RST_CONFIG = 1'h0;
   localparam int FN_CMP_OUT = 0;
   localparam int FN_PWM_B = 1;
   localparam int FN_PWM_C = 2;
   localparam int FN_PWM_D = 3;
   localparam int FN_VREF_OUT = 4;
   localparam int FN_TRI_B = 5;
   localparam int FN_TRI_C = 6;
   localparam int FN_TRI_D = 7;
   localparam int CFG_LVP = 0;
   localparam int ST_EXTERNAL_INTERRUPT_0 = 0;
   localparam int ST_PROG = 3;
   localparam int ST_CMP = 4;
   localparam int ST_SHUTDOWN = 5;
   localparam int PS_OUT = 0;
   localparam int PS_OE_N = 8;
   localparam int PIN_VREF = 2;
   localparam int PIN_PROG = 3;
   localparam int PIN_CMP = 4;
   localparam int PIN_PWM_B = 4;
   localparam int PIN_PWM_C = 3;
   localparam int PIN_PWM_D = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : pinmux_pkg
`default_nettype wire

// ### pinmux_properties.sv
// concurrent checks on the pin mux top ports
// assumes one clock aclk and synchronous active-low aresetn
`default_nettype none
module pinmux_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [pinmux_pkg::DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [pinmux_pkg::PIN_COUNT-1:0] pin_in,
   input wire logic [pinmux_pkg::PIN_COUNT-1:0] pin_oe_n,
   input wire logic [2:0] external_interrupt,
   input wire logic [pinmux_pkg::ANA_COUNT-1:0] converter_channel_en,
   input wire logic comparator_noninverting_input_en,
   input wire logic [2:0] comparator_inverting_input_en,
   input wire logic vref_high_input_en,
   input wire logic vref_low_input_en,
   input wire logic reference_voltage_output_en,
   input wire logic programming_entry_pin
);
   import pinmux_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles pin 0 has been a digital input; two sync flops plus the interrupt flop need three
   logic [2:0] dig_cnt_ff;
   logic [2:0] nxt_dig_cnt;
   always_comb begin
      nxt_dig_cnt = dig_cnt_ff;
      if (!pin_oe_n[0] || converter_channel_en[0]) nxt_dig_cnt = 3'h0;
      else if (dig_cnt_ff != 3'h7) nxt_dig_cnt = dig_cnt_ff + 3'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) dig_cnt_ff <= 3'h0;
      else dig_cnt_ff <= nxt_dig_cnt;
   end
   property p_ana_in; (converter_channel_en & ~pin_oe_n[3:0]) == 4'h0; endproperty
   a_ana_in: assert property (p_ana_in) else $error("analogue route on output pin");
   property p_cmp_sel;
      {comparator_inverting_input_en, comparator_noninverting_input_en} == converter_channel_en;
   endproperty
   a_cmp_sel: assert property (p_cmp_sel) else $error("comparator select differs");
   property p_vref_in; {vref_low_input_en, vref_high_input_en} == converter_channel_en[1:0];
   endproperty
   a_vref_in: assert property (p_vref_in) else $error("reference input select wrong");
   property p_int_in;
      (external_interrupt & ~(pin_oe_n[2:0] & ~converter_channel_en[2:0])) == 3'h0;
   endproperty
   a_int_in: assert property (p_int_in) else $error("interrupt from non-input pin");
   property p_int_follow; dig_cnt_ff > 3'h3 && pin_oe_n[0] && !converter_channel_en[0] |->
      external_interrupt[0] == $past(pin_in[0], 3); endproperty
   a_int_follow: assert property (p_int_follow) else $error("interrupt 0 stale");
   property p_vref_cut; reference_voltage_output_en && $past(reference_voltage_output_en) |->
      pin_oe_n[2] && !converter_channel_en[2] && !external_interrupt[2]; endproperty
   a_vref_cut: assert property (p_vref_cut) else $error("pin 2 not cut off");
   property p_prog_cut; programming_entry_pin |-> pin_oe_n[3] && !converter_channel_en[3];
   endproperty
   a_prog_cut: assert property (p_prog_cut) else $error("pin 3 not cut off");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_wr_lat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   c_ana: cover property (converter_channel_en[3]);
   c_vref: cover property (reference_voltage_output_en && pin_oe_n[2]);
   c_prog: cover property (programming_entry_pin);
endmodule : pinmux_checker
bind port_c_pin_function_mux pinmux_checker pinmux_checker_i (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .rdata, .rvalid, .rready, .pin_in,
   .pin_oe_n, .external_interrupt, .converter_channel_en, .comparator_noninverting_input_en,
   .comparator_inverting_input_en, .vref_high_input_en, .vref_low_input_en,
   .reference_voltage_output_en, .programming_entry_pin);
`default_nettype wire

// ### port_c_pin_function_mux.sv
// port c pin function multiplexer: register file, per-pin source select, pin drivers
// assumes peripheral sources share aclk; pin levels are asynchronous and get synchronised
`default_nettype none
module port_c_pin_function_mux (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pinmux_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [pinmux_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pinmux_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [pinmux_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [pinmux_pkg::PIN_COUNT-1:0] pin_in,
   output logic [pinmux_pkg::PIN_COUNT-1:0] pin_out,
   output logic [pinmux_pkg::PIN_COUNT-1:0] pin_oe_n,
   input wire logic comparator_1_result,
   input wire logic comparator_2_result,
   input wire logic pwm_channel_b_output,
   input wire logic pwm_channel_c_output,
   input wire logic pwm_channel_d_output,
   input wire logic pwm_shutdown_active,
   output logic [2:0] external_interrupt,
   output logic [pinmux_pkg::ANA_COUNT-1:0] converter_channel_en,
   output logic comparator_noninverting_input_en,
   output logic [2:0] comparator_inverting_input_en,
   output logic vref_high_input_en,
   output logic vref_low_input_en,
   output logic reference_voltage_output_en,
   output logic programming_entry_pin
);
   import pinmux_pkg::*;

   reg_access_if regs ();

   logic [PIN_COUNT-1:0] pin_sync;
   logic [4:0] dir_ff, nxt_dir;
   logic [4:0] latch_ff, nxt_latch;
   logic [7:0] fn_ff, nxt_fn;
   logic [3:0] ana_ff, nxt_ana;
   logic [0:0] cfg_ff, nxt_cfg;
   logic [PIN_COUNT-1:0] out_ff, nxt_out;
   logic [PIN_COUNT-1:0] oe_n_ff, nxt_oe_n;
   logic [PIN_COUNT-1:0] in_val_ff, nxt_in_val;
   logic [2:0] int_ff, nxt_int;
   logic [ANA_COUNT-1:0] route_ff, nxt_route;
   logic vref_ff, nxt_vref;
   logic prog_ff, nxt_prog;
   logic [PIN_COUNT-1:0] ana_wide;
   logic [PIN_COUNT-1:0] dig_in;
   logic [PIN_COUNT-1:0] cut;
   logic cmp_combined;
   logic lvp_on;
   logic vref_on;
   logic [DATA_W-1:0] rd_data_c;
   logic rd_err_c;
   logic wr_err_c;

   input_sync #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(pin_in),
      .dout(pin_sync)
   );

   axil_port u_axil_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .regs(regs)
   );

   // [RQ1] comparators merged
   assign cmp_combined = comparator_1_result | comparator_2_result;
   assign lvp_on = cfg_ff[CFG_LVP];
   assign vref_on = fn_ff[FN_VREF_OUT];
   assign ana_wide = {1'b0, ana_ff};

   // register writes; only byte lane 0 carries fields
   always_comb begin
      nxt_dir = dir_ff;
      nxt_latch = latch_ff;
      nxt_fn = fn_ff;
      nxt_ana = ana_ff;
      nxt_cfg = cfg_ff;
      wr_err_c = 1'b0;
      case ({regs.wr_addr[ADDR_W-1:2], 2'b00})
         OFS_DIRECTION, OFS_LATCH, OFS_FUNCTION, OFS_ANALOG, OFS_CONFIG,
         OFS_INPUT, OFS_STATUS, OFS_PIN_STATE: wr_err_c = 1'b0;
         default: wr_err_c = 1'b1;
      endcase
      if (regs.wr_en && regs.wr_strb[0]) begin
         case ({regs.wr_addr[ADDR_W-1:2], 2'b00})
            OFS_DIRECTION: nxt_dir = regs.wr_data[4:0];
            OFS_LATCH: nxt_latch = regs.wr_data[4:0];
            OFS_FUNCTION: nxt_fn = regs.wr_data[7:0];
            OFS_ANALOG: nxt_ana = regs.wr_data[3:0];
            OFS_CONFIG: nxt_cfg = regs.wr_data[0:0];
            default: nxt_dir = dir_ff;
         endcase
      end
   end
   assign regs.wr_err = wr_err_c;

   // reads see registered state, except the live comparator and shutdown status bits; read-only words ignore writes
   always_comb begin
      rd_data_c = '0;
      rd_err_c = 1'b0;
      case ({regs.rd_addr[ADDR_W-1:2], 2'b00})
         OFS_DIRECTION: rd_data_c[4:0] = dir_ff;
         OFS_LATCH: rd_data_c[4:0] = latch_ff;
         // [RQ11] port input value
         OFS_INPUT: rd_data_c[PIN_COUNT-1:0] = in_val_ff;
         OFS_FUNCTION: rd_data_c[7:0] = fn_ff;
         OFS_ANALOG: rd_data_c[3:0] = ana_ff;
         OFS_CONFIG: rd_data_c[0:0] = cfg_ff;
         OFS_STATUS: begin
            rd_data_c[ST_EXTERNAL_INTERRUPT_0+2:ST_EXTERNAL_INTERRUPT_0] = int_ff;
            rd_data_c[ST_PROG] = prog_ff;
            rd_data_c[ST_CMP] = cmp_combined;
            rd_data_c[ST_SHUTDOWN] = pwm_shutdown_active;
         end
         OFS_PIN_STATE: begin
            rd_data_c[PS_OUT+PIN_COUNT-1:PS_OUT] = out_ff;
            rd_data_c[PS_OE_N+PIN_COUNT-1:PS_OE_N] = oe_n_ff;
         end
         default: rd_err_c = 1'b1;
      endcase
   end
   assign regs.rd_data = rd_data_c;
   assign regs.rd_err = rd_err_c;

   // per-pin source selection
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic pwm_sel;
      logic pwm_val;
      logic pwm_tri;
      logic cmp_sel;
      logic drive;
      always_comb begin
         pwm_sel = 1'b0;
         pwm_val = 1'b0;
         pwm_tri = 1'b0;
         cmp_sel = 1'b0;
         // [RQ2] pwm steering
         if (i == PIN_PWM_B) begin
            pwm_sel = fn_ff[FN_PWM_B];
            pwm_val = pwm_channel_b_output;
            pwm_tri = fn_ff[FN_TRI_B];
         end else if (i == PIN_PWM_C) begin
            pwm_sel = fn_ff[FN_PWM_C];
            pwm_val = pwm_channel_c_output;
            pwm_tri = fn_ff[FN_TRI_C];
         end else if (i == PIN_PWM_D) begin
            pwm_sel = fn_ff[FN_PWM_D];
            pwm_val = pwm_channel_d_output;
            pwm_tri = fn_ff[FN_TRI_D];
         end
         // [RQ1] comparator output pin
         if (i == PIN_CMP) begin
            cmp_sel = fn_ff[FN_CMP_OUT];
         end
         // [RQ4] [RQ5] [RQ9] overrides ignore direction
         cut[i] = (vref_on && (i == PIN_VREF)) || (lvp_on && (i == PIN_PROG));
         // [RQ11] output direction drives
         drive = !dir_ff[i] && !cut[i];
         // [RQ3] float during shutdown
         nxt_oe_n[i] = !(drive && !(pwm_sel && pwm_tri && pwm_shutdown_active));
         // pwm wins over comparator where both share a pin
         if (pwm_sel) begin
            nxt_out[i] = pwm_val;
         end else if (cmp_sel) begin
            nxt_out[i] = cmp_combined;
         end else begin
            nxt_out[i] = latch_ff[i];
         end
         // analogue select also shuts the digital input buffer
         dig_in[i] = pin_sync[i] && !cut[i] && !ana_wide[i];
         // [RQ11] input read through port value
         nxt_in_val[i] = dig_in[i];
      end
   end

   // peripheral inputs taken from the pins
   always_comb begin
      // [RQ6] interrupts need input direction
      nxt_int = dig_in[2:0] & dir_ff[2:0];
      // [RQ7] [RQ8] shared analogue routing
      nxt_route = ana_ff & dir_ff[3:0] & ~cut[3:0];
      nxt_vref = vref_on;
      // [RQ5] programming entry input
      nxt_prog = lvp_on && pin_sync[PIN_PROG];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_ff <= RST_DIRECTION;
         latch_ff <= RST_LATCH;
         fn_ff <= RST_FUNCTION;
         ana_ff <= RST_ANALOG;
         cfg_ff <= RST_CONFIG;
         out_ff <= '0;
         oe_n_ff <= '1;
         in_val_ff <= '0;
         int_ff <= '0;
         route_ff <= '0;
         vref_ff <= 1'b0;
         prog_ff <= 1'b0;
      end else begin
         dir_ff <= nxt_dir;
         latch_ff <= nxt_latch;
         fn_ff <= nxt_fn;
         ana_ff <= nxt_ana;
         cfg_ff <= nxt_cfg;
         out_ff <= nxt_out;
         oe_n_ff <= nxt_oe_n;
         in_val_ff <= nxt_in_val;
         int_ff <= nxt_int;
         route_ff <= nxt_route;
         vref_ff <= nxt_vref;
         prog_ff <= nxt_prog;
      end
   end

   assign pin_out = out_ff;
   assign pin_oe_n = oe_n_ff;
   assign external_interrupt = int_ff;
   assign converter_channel_en = route_ff;
   // [RQ8] comparator inputs follow converter select
   assign comparator_noninverting_input_en = route_ff[0];
   assign comparator_inverting_input_en = route_ff[3:1];
   // [RQ10] reference inputs on pins 0 and 1
   assign vref_high_input_en = route_ff[0];
   assign vref_low_input_en = route_ff[1];
   assign reference_voltage_output_en = vref_ff;
   assign programming_entry_pin = prog_ff;
endmodule : port_c_pin_function_mux
`default_nettype wire

// ### reg_access_if.sv
// simple register access strobes between the bus port and the register file
// assumes both ends run on the same clock
`default_nettype none
interface reg_access_if;
   logic wr_en;
   logic [pinmux_pkg::ADDR_W-1:0] wr_addr;
   logic [pinmux_pkg::DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic rd_en;
   logic [pinmux_pkg::ADDR_W-1:0] rd_addr;
   logic [pinmux_pkg::DATA_W-1:0] rd_data;
   logic rd_err;
   modport initiator(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                     input wr_err, rd_data, rd_err);
   modport target(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : reg_access_if
`default_nettype wire

// ### tb.sv
// self-checking bench for the port c pin mux, registers over AXI4-Lite
// assumes the pin partner closes the loop from pin_out back to pin_in
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pinmux_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, reference_voltage_output_en, programming_entry_pin;
   logic comparator_1_result, comparator_2_result, pwm_shutdown_active;
   logic pwm_channel_b_output, pwm_channel_c_output, pwm_channel_d_output;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, converter_channel_en;
   logic [1:0] bresp, rresp;
   logic [2:0] awprot, arprot, external_interrupt, p;
   logic [4:0] pin_in, pin_out, pin_oe_n, ext_val, ext_en, r;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int error_cnt, samples_checked, cyc;
   port_c_pin_function_mux port_c_pin_function_mux_i (.aclk, .aresetn, .awaddr, .awprot,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out,
      .pin_oe_n, .comparator_1_result, .comparator_2_result, .pwm_channel_b_output,
      .pwm_channel_c_output, .pwm_channel_d_output, .pwm_shutdown_active, .external_interrupt,
      .converter_channel_en, .comparator_noninverting_input_en(),
      .comparator_inverting_input_en(), .vref_high_input_en(), .vref_low_input_en(),
      .reference_voltage_output_en, .programming_entry_pin);
   pin_partner pin_partner_i (.pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_in);
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] e = RESP_OKAY);
      bit ap, wp;
      bq.push_back(e);
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      ap = 1; wp = 1;
      while (ap || wp) begin
         @(posedge aclk);
         if (ap && awready === 1'b1) begin awvalid <= 1'b0; ap = 0; end
         if (wp && wready === 1'b1) begin wvalid <= 1'b0; wp = 0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
      rq.push_back({e, d});
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd
   function automatic logic [31:0] ps(input logic [4:0] o, input logic [4:0] oen);
      return {19'h0, oen, 3'h0, o};
   endfunction : ps
   // oldest note against each accepted response
   always @(posedge aclk) begin
      if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
         check({rresp, rdata}, rq.pop_front());
      if (aresetn === 1'b1 && bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
         check({32'h0, bresp}, {32'h0, bq.pop_front()});
   end
   // hang guard, well above the run length
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      void'($urandom(84));
      {aresetn, awvalid, wvalid, bready, arvalid, rready, pwm_shutdown_active} = '0;
      {comparator_1_result, comparator_2_result, awaddr, araddr, wdata, wstrb} = '0;
      {pwm_channel_b_output, pwm_channel_c_output, pwm_channel_d_output} = '0;
      {awprot, arprot, ext_val, ext_en} = '0;
      wt(20);
      aresetn <= 1'b1;
      rd(OFS_DIRECTION, 32'(RST_DIRECTION));
      rd(OFS_LATCH, 32'(RST_LATCH));
      rd(OFS_FUNCTION, 32'(RST_FUNCTION));
      rd(OFS_ANALOG, 32'(RST_ANALOG));
      rd(OFS_CONFIG, 32'(RST_CONFIG));
      rd(OFS_PIN_STATE, ps(5'h00, 5'h1F));
      rd(8'h20, 32'h0, RESP_DECERR);
      wr(8'h24, 32'h1, 4'hF, RESP_DECERR);
      r = 5'($urandom);
      wr(OFS_LATCH, 32'(r));
      wr(OFS_DIRECTION, 32'h0);
      wr(OFS_LATCH, 32'h1F, 4'h0);
      wr(OFS_INPUT, 32'h1F);
      wt(2);
      rd(OFS_PIN_STATE, ps(r, 5'h00));
      rd(OFS_LATCH, 32'(r));
      r = 5'($urandom);
      wr(OFS_DIRECTION, 32'h1F);
      ext_val <= r;
      ext_en <= 5'h1F;
      wt(5);
      rd(OFS_INPUT, 32'(r));
      rd(OFS_STATUS, 32'(r[2:0]));
      ext_en <= 5'h00;
      wt(5);
      rd(OFS_INPUT, 32'h1F);
      wr(OFS_LATCH, 32'h1F);
      wr(OFS_DIRECTION, 32'h0);
      wr(OFS_FUNCTION, 32'h01);
      for (int i = 0; i < 4; i++) begin
         {comparator_1_result, comparator_2_result} <= 2'(i);
         wt(3);
         rd(OFS_PIN_STATE, ps({i != 0, 4'hF}, 5'h00));
         rd(OFS_STATUS, 32'(i != 0) << ST_CMP);
      end
      {comparator_1_result, comparator_2_result} <= 2'b00;
      wr(OFS_LATCH, 32'h0);
      // float only with the tri-state bits set and shutdown active
      for (int i = 0; i < 4; i++) begin
         p = 3'($urandom);
         wr(OFS_FUNCTION, i[1] ? 32'hEE : 32'h0E);
         {pwm_channel_b_output, pwm_channel_c_output, pwm_channel_d_output} <= p;
         pwm_shutdown_active <= i[0];
         wt(3);
         rd(OFS_PIN_STATE, ps({p, 2'b00}, {{3{i == 3}}, 2'b00}));
      end
      rd(OFS_STATUS, 32'h1 << ST_SHUTDOWN);
      pwm_shutdown_active <= 1'b0;
      wr(OFS_FUNCTION, 32'h10);
      wr(OFS_LATCH, 32'h1F);
      ext_val <= 5'h1F;
      ext_en <= 5'h1F;
      wt(5);
      check({29'h0, pin_oe_n}, 34'h04);
      check({33'h0, reference_voltage_output_en}, 34'h1);
      rd(OFS_INPUT, 32'h1B);
      wr(OFS_FUNCTION, 32'h0);
      wr(OFS_CONFIG, 32'h1);
      wt(5);
      check({29'h0, pin_oe_n}, 34'h08);
      check({33'h0, programming_entry_pin}, 34'h1);
      rd(OFS_INPUT, 32'h17);
      wr(OFS_CONFIG, 32'h0);
      wr(OFS_DIRECTION, 32'h1F);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_ANALOG, 32'h1 << k);
         wt(3);
         check({30'h0, converter_channel_en}, 34'h1 << k);
         rd(OFS_INPUT, 32'h1F & ~(32'h1 << k));
      end
      wr(OFS_DIRECTION, 32'h0);
      wt(3);
      check({30'h0, converter_channel_en}, 34'h0);
      wt(2);
      finish_test();
   end
endmodule : tb
`default_nettype wire
